// >>> hdl/tir_defs.svh
/*
 * Register offsets, field positions and reset values of the tag interrupt block.
 * Assumes inclusion by bare name from the design files of this block only.
 */
// Behaviour
// RULE_01 - Bits 7 to 4 of the reader frame parameter register show the frame-size index sent by the reader.
// RULE_02 - Bits 3 to 0 of the reader frame parameter register show the card identifier given by the reader.
// RULE_03 - The reader frame parameter register is zero after power-up and after the restore-defaults command.
// RULE_04 - The reader frame parameter register only takes new values in the Level-4 protocol mode.
// RULE_05 - Main mask bits 7 and 6 default to 1 and are forced to 0 at power-up when their enable bit is set.
// RULE_06 - Main mask bits 5 to 1 default to 0 and bit 0 is reserved.
// RULE_07 - Both mask registers reload their defaults at power-up and on the restore-defaults command.
// RULE_08 - The auxiliary mask holds eight masks, all defaulting to 0.
// RULE_09 - Main flag bits 7, 6 and 5 flag power-up, entry into the active state and the wake-up command.
// RULE_10 - Receive start and end flags are set only for frames delivered into the FIFO.
// RULE_11 - The transmit end flag is set only when a transmission fed from the FIFO completes.
// RULE_12 - While receiving, the water-level flag is set when the FIFO is nearly full.
// RULE_13 - While transmitting, the water-level flag is set when the FIFO is nearly empty so the host refills it.
// RULE_14 - Main flag bit 0 is set whenever an auxiliary event is pending.
// RULE_15 - Reading the main flag register clears all its bits except bit 0.
// RULE_16 - Main flag bit 0 clears only when the auxiliary flag register is read. The code also clears it on restore-defaults when no auxiliary event is pending.
// RULE_17 - The interrupt output is high while any unmasked flag is set, and masked sources never drive it.
`ifndef TIR_DEFS_SVH
`define TIR_DEFS_SVH

`define TIR_ADDR_RFP        8'h05
`define TIR_ADDR_MAIN_MASK  8'h08
`define TIR_ADDR_AUX_MASK   8'h09
`define TIR_ADDR_MAIN_FLAGS 8'h0A
`define TIR_ADDR_AUX_FLAGS  8'h0B

`define TIR_MAIN_MASK_RST   8'hC0
`define TIR_AUX_MASK_RST    8'h00
`define TIR_RFP_RST         8'h00
`define TIR_FLAGS_RST       8'h00
`define TIR_RDATA_NONE      8'h00
`define TIR_MAIN_RD_CLR     8'hFE
`define TIR_MAIN_MASK_WMASK 8'hFE

`define TIR_BIT_PU          7
`define TIR_BIT_ACT         6
`define TIR_BIT_WAKE        5
`define TIR_BIT_RXS         4
`define TIR_BIT_RXE         3
`define TIR_BIT_TXE         2
`define TIR_BIT_WL          1
`define TIR_BIT_AUX         0

`define TIR_FSDI_HI         7
`define TIR_FSDI_LO         4
`define TIR_CID_HI          3
`define TIR_CID_LO          0

`define TIR_MODE_L4         2'h0

`endif

// >>> hdl/tir_flag_bank.sv
/*
 * Bank of sticky event flags; a set in the same cycle as a clear wins.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tir_flag_bank #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output var  logic [W-1:0] flags
);
	logic [W-1:0] flags_reg;
	logic [W-1:0] flags_next;

	// Refuse a bank with no flags while elaborating, not at run time
	if (W < 1)
	begin : g_bad_width
		$error("tir_flag_bank: W must be at least 1");
	end

	// Per-bit sticky flag; set beats clear so no event is lost
	generate
		for (genvar i = 0; i < W; i++)
		begin : g_bit
			always_comb
			begin
				flags_next[i] = set[i] | (flags_reg[i] & ~clr[i]);
			end

			a_set_wins : assert property (@(posedge mclk) disable iff (!rst_n)
				rst_n && set[i] |=> flags_reg[i]) // Sampled reset skips the release edge
				else $error("flag lost its set");
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			flags_reg <= '0;
		else
			flags_reg <= flags_next;
	end

	assign flags = flags_reg;

endmodule

`default_nettype wire

// >>> hdl/tir_irq_ctrl.sv
/*
 * Interrupt flags, masks and reader frame parameter display of the tag front-end.
 * Assumes the serial slave, tag protocol logic and nonvolatile configuration all run on mclk;
 * the auxiliary flag register lives elsewhere and its content arrives on aux_flags.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tir_defs.svh"

module tir_irq_ctrl (
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	input  wire tir_pkg::tir_reg_req_t reg_req,
	output var  logic [7:0]           reg_rdata,
	input  wire tir_pkg::tir_events_t events,
	input  wire logic [7:0]           aux_flags,
	input  wire logic [1:0]           proto_mode,
	input  wire logic                 rats_valid,
	input  wire logic [3:0]           rats_fsdi,
	input  wire logic [3:0]           rats_cid,
	input  wire logic                 set_default,
	input  wire logic                 nvm_enable_powerup_irq,
	input  wire logic                 nvm_enable_active_irq,
	output var  logic                 irq
);
	import tir_pkg::*;

	logic [1:0] rst_sync_reg;
	logic       rst_n;

	tir_state_t state_reg;
	tir_state_t state_next;
	logic [7:0] main_irq_mask_reg;
	logic [7:0] main_irq_mask_next;
	logic [7:0] aux_irq_mask_reg;
	logic [7:0] aux_irq_mask_next;
	logic [7:0] reader_frame_params_reg;
	logic [7:0] reader_frame_params_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       irq_reg;
	logic       irq_next;
	logic       wl_cond_reg;
	logic       wl_cond_next;

	logic       wl_cond;
	logic       wl_rise;
	logic       rd_main;
	logic       rd_aux;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic [7:0] main_irq_flags;

	// Reset release through two flops; only the second is read
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	assign rst_n = rst_sync_reg[1];

	// Water level condition; edge so a lingering level sets the flag once per crossing
	assign wl_cond = (events.rx_active & events.fifo_near_full)     // [RULE_12]
		| (events.tx_active & events.fifo_near_empty);              // [RULE_13]
	assign wl_rise = wl_cond & ~wl_cond_reg;
	assign rd_main = reg_req.rd && (reg_req.addr == `TIR_ADDR_MAIN_FLAGS);
	assign rd_aux  = reg_req.rd && (reg_req.addr == `TIR_ADDR_AUX_FLAGS);

	// Flag sources and clears
	always_comb
	begin
		flag_set = `TIR_FLAGS_RST;
		flag_set[`TIR_BIT_PU]   = (state_reg == ST_INIT);                  // [RULE_09]
		flag_set[`TIR_BIT_ACT]  = events.active_entry;                     // [RULE_09]
		flag_set[`TIR_BIT_WAKE] = events.wake_cmd;                         // [RULE_09]
		flag_set[`TIR_BIT_RXS]  = events.rx_start & events.rx_to_fifo;     // [RULE_10]
		flag_set[`TIR_BIT_RXE]  = events.rx_end & events.rx_to_fifo;       // [RULE_10]
		flag_set[`TIR_BIT_TXE]  = events.tx_end & events.tx_from_fifo;     // [RULE_11]
		flag_set[`TIR_BIT_WL]   = wl_rise;                                 // [RULE_12] [RULE_13]
		flag_set[`TIR_BIT_AUX]  = |aux_flags;                              // [RULE_14]
		flag_clr = `TIR_FLAGS_RST;
		if (set_default)
			flag_clr = ~`TIR_FLAGS_RST;
		if (rd_main)
			flag_clr = flag_clr | `TIR_MAIN_RD_CLR;                        // [RULE_15]
		if (rd_aux)
			flag_clr[`TIR_BIT_AUX] = 1'b1;                                 // [RULE_16]
	end

	tir_flag_bank #(
		.W (8)
	) u_flags (
		.mclk  (mclk),
		.rst_n (rst_n),
		.set   (flag_set),
		.clr   (flag_clr),
		.flags (main_irq_flags)
	);

	// Next values of masks, display register, read data and interrupt
	always_comb
	begin
		state_next               = ST_RUN;
		main_irq_mask_next       = main_irq_mask_reg;
		aux_irq_mask_next        = aux_irq_mask_reg;
		reader_frame_params_next = reader_frame_params_reg;
		rdata_next               = rdata_reg;
		wl_cond_next             = wl_cond;
		case (state_reg)
			ST_INIT:
			begin
				// Configuration enables unmask the two early sources
				main_irq_mask_next = `TIR_MAIN_MASK_RST;
				if (nvm_enable_powerup_irq)
					main_irq_mask_next[`TIR_BIT_PU] = 1'b0;            // [RULE_05]
				if (nvm_enable_active_irq)
					main_irq_mask_next[`TIR_BIT_ACT] = 1'b0;           // [RULE_05]
			end
			ST_RUN:
			begin
				if (reg_req.wr && reg_req.addr == `TIR_ADDR_MAIN_MASK)
					main_irq_mask_next = reg_req.wdata & `TIR_MAIN_MASK_WMASK; // [RULE_06]
				if (reg_req.wr && reg_req.addr == `TIR_ADDR_AUX_MASK)
					aux_irq_mask_next = reg_req.wdata;                 // [RULE_08]
			end
			default:
			begin
				state_next = ST_INIT;
			end
		endcase
		// Only the Level-4 engine decodes the request; other modes leave it alone
		if (rats_valid && proto_mode == `TIR_MODE_L4)                  // [RULE_04]
		begin
			reader_frame_params_next[`TIR_FSDI_HI:`TIR_FSDI_LO] = rats_fsdi; // [RULE_01]
			reader_frame_params_next[`TIR_CID_HI:`TIR_CID_LO]   = rats_cid;  // [RULE_02]
		end
		// Restore-defaults outranks any write in the same cycle
		if (set_default)
		begin
			main_irq_mask_next       = `TIR_MAIN_MASK_RST;               // [RULE_07]
			aux_irq_mask_next        = `TIR_AUX_MASK_RST;                // [RULE_07]
			reader_frame_params_next = `TIR_RFP_RST;                     // [RULE_03]
		end
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				`TIR_ADDR_RFP:        rdata_next = reader_frame_params_reg;
				`TIR_ADDR_MAIN_MASK:  rdata_next = main_irq_mask_reg;
				`TIR_ADDR_AUX_MASK:   rdata_next = aux_irq_mask_reg;
				`TIR_ADDR_MAIN_FLAGS: rdata_next = main_irq_flags;
				`TIR_ADDR_AUX_FLAGS:  rdata_next = aux_flags;
				default:              rdata_next = `TIR_RDATA_NONE;
			endcase
		end
		// Bit 0 carries the aux summary, so auxiliary sources use their own masks
		irq_next = (|(main_irq_flags & ~main_irq_mask_reg & `TIR_MAIN_MASK_WMASK))
			| (|(aux_flags & ~aux_irq_mask_reg));                         // [RULE_17]
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg               <= ST_INIT;
			main_irq_mask_reg       <= `TIR_MAIN_MASK_RST;
			aux_irq_mask_reg        <= `TIR_AUX_MASK_RST;
			reader_frame_params_reg <= `TIR_RFP_RST;
			rdata_reg               <= `TIR_RDATA_NONE;
			irq_reg                 <= 1'b0;
			wl_cond_reg             <= 1'b0;
		end
		else
		begin
			state_reg               <= state_next;
			main_irq_mask_reg       <= main_irq_mask_next;
			aux_irq_mask_reg        <= aux_irq_mask_next;
			reader_frame_params_reg <= reader_frame_params_next;
			rdata_reg               <= rdata_next;
			irq_reg                 <= irq_next;
			wl_cond_reg             <= wl_cond_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign irq       = irq_reg;

	// Checks on the display register, masks, flags and interrupt
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_rfp_fsdi_load : assert property ( // [RULE_01]
		rats_valid && proto_mode == `TIR_MODE_L4 && !set_default
		|=> reader_frame_params_reg[`TIR_FSDI_HI:`TIR_FSDI_LO] == $past(rats_fsdi))
		else $error("frame size index not captured");

	a_rfp_cid_load : assert property ( // [RULE_02]
		rats_valid && proto_mode == `TIR_MODE_L4 && !set_default
		|=> reader_frame_params_reg[`TIR_CID_HI:`TIR_CID_LO] == $past(rats_cid))
		else $error("card identifier not captured");

	a_rfp_default_zero : assert property ( // [RULE_03]
		set_default |=> reader_frame_params_reg == `TIR_RFP_RST)
		else $error("frame parameters not cleared");

	a_rfp_mode_gate : assert property ( // [RULE_04]
		!set_default && !(rats_valid && proto_mode == `TIR_MODE_L4)
		|=> $stable(reader_frame_params_reg))
		else $error("frame parameters changed outside Level-4");

	a_init_mask_nvm : assert property ( // [RULE_05]
		$rose(state_reg == ST_RUN) && !$past(set_default)
		|-> main_irq_mask_reg[`TIR_BIT_PU] == !$past(nvm_enable_powerup_irq)
		&& main_irq_mask_reg[`TIR_BIT_ACT] == !$past(nvm_enable_active_irq))
		else $error("power-up mask not taken from configuration");

	a_mask_reserved : assert property ( // [RULE_06]
		main_irq_mask_reg[`TIR_BIT_AUX] == 1'b0)
		else $error("reserved mask bit set");

	a_mask_restore : assert property ( // [RULE_07]
		set_default |=> main_irq_mask_reg == `TIR_MAIN_MASK_RST
		&& aux_irq_mask_reg == `TIR_AUX_MASK_RST)
		else $error("masks not restored");

	a_powerup_flag : assert property ( // [RULE_09]
		state_reg == ST_INIT ##1 state_reg == ST_RUN |-> main_irq_flags[`TIR_BIT_PU])
		else $error("power-up flag missing");

	a_rx_fifo_only : assert property ( // [RULE_10]
		!main_irq_flags[`TIR_BIT_RXS] && !(events.rx_start && events.rx_to_fifo)
		|=> !main_irq_flags[`TIR_BIT_RXS])
		else $error("receive start flagged without FIFO frame");

	a_tx_fifo_only : assert property ( // [RULE_11]
		!main_irq_flags[`TIR_BIT_TXE] && !(events.tx_end && events.tx_from_fifo)
		|=> !main_irq_flags[`TIR_BIT_TXE])
		else $error("transmit end flagged without FIFO payload");

	a_water_level : assert property ( // [RULE_12] [RULE_13]
		wl_cond && !wl_cond_reg |=> main_irq_flags[`TIR_BIT_WL])
		else $error("water level not flagged");

	a_aux_summary : assert property ( // [RULE_14]
		|aux_flags |=> main_irq_flags[`TIR_BIT_AUX])
		else $error("aux summary not set");

	a_main_read_clr : assert property ( // [RULE_15]
		rd_main && flag_set == `TIR_FLAGS_RST && !rd_aux && !set_default
		|=> main_irq_flags == ($past(main_irq_flags) & ~`TIR_MAIN_RD_CLR))
		else $error("main read did not clear");

	a_aux_bit_hold : assert property ( // [RULE_16]
		main_irq_flags[`TIR_BIT_AUX] && !rd_aux && !set_default
		|=> main_irq_flags[`TIR_BIT_AUX])
		else $error("aux summary cleared without aux read");

	a_irq_follows : assert property ( // [RULE_17]
		(main_irq_flags & ~main_irq_mask_reg & `TIR_MAIN_MASK_WMASK) == `TIR_FLAGS_RST
		&& (aux_flags & ~aux_irq_mask_reg) == `TIR_FLAGS_RST |=> !irq_reg)
		else $error("interrupt from masked source");

	a_irq_unmasked : assert property ( // [RULE_17]
		(main_irq_flags & ~main_irq_mask_reg & `TIR_MAIN_MASK_WMASK) != `TIR_FLAGS_RST
		|=> irq_reg)
		else $error("unmasked flag gave no interrupt");

	a_main_mask_write : assert property ( // [RULE_06]
		reg_req.wr && reg_req.addr == `TIR_ADDR_MAIN_MASK
		&& state_reg == ST_RUN && !set_default
		|=> main_irq_mask_reg == ($past(reg_req.wdata) & `TIR_MAIN_MASK_WMASK))
		else $error("main mask write lost");

	a_aux_mask_write : assert property ( // [RULE_08]
		reg_req.wr && reg_req.addr == `TIR_ADDR_AUX_MASK
		&& state_reg == ST_RUN && !set_default
		|=> aux_irq_mask_reg == $past(reg_req.wdata))
		else $error("auxiliary mask write lost");

	a_rx_end_fifo : assert property ( // [RULE_10]
		!main_irq_flags[`TIR_BIT_RXE] && !(events.rx_end && events.rx_to_fifo)
		|=> !main_irq_flags[`TIR_BIT_RXE])
		else $error("receive end flagged without FIFO frame");

	a_aux_read_clr : assert property ( // [RULE_16]
		rd_aux && aux_flags == `TIR_FLAGS_RST |=> !main_irq_flags[`TIR_BIT_AUX])
		else $error("aux summary kept after aux read");

	// The host sees the flags as they stood before the read cleared them
	a_main_rdata : assert property ( // [RULE_15]
		rd_main |=> rdata_reg == $past(main_irq_flags))
		else $error("main flag read returned wrong value");

	c_rats_capture : cover property (rats_valid && proto_mode == `TIR_MODE_L4);
	c_irq_rise     : cover property (!irq_reg ##1 irq_reg);
	c_main_read    : cover property (rd_main && main_irq_flags != `TIR_FLAGS_RST);
	c_wl_set       : cover property (wl_rise);
	c_aux_clear    : cover property (rd_aux && main_irq_flags[`TIR_BIT_AUX]);

endmodule

`default_nettype wire

// >>> hdl/tir_pkg.sv
/*
 * Types shared by the tag interrupt block: register request, event bundle, states.
 * Assumes tir_defs.svh is compiled alongside.
 */
`default_nettype none

package tir_pkg;

	// Register access from the serial slave, same clock
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tir_reg_req_t;

	// Event strobes and levels from the tag logic, same clock
	typedef struct packed {
		logic active_entry;
		logic wake_cmd;
		logic rx_start;
		logic rx_end;
		logic rx_to_fifo;
		logic tx_end;
		logic tx_from_fifo;
		logic rx_active;
		logic tx_active;
		logic fifo_near_full;
		logic fifo_near_empty;
	} tir_events_t;

	typedef enum logic {
		ST_INIT,
		ST_RUN
	} tir_state_t;

endpackage

`default_nettype wire

// >>> verif/tag_interrupt_and_rats_display_bench.sv
/*
 * Self-checking bench for the tag interrupt block: masks, flags, irq and reader parameters.
 * Assumes the host model drives the register port and the bench drives all event inputs.
 */
`timescale 1ns/1ps
`default_nettype none

module tag_interrupt_and_rats_display_bench;
	import tir_pkg::*;

	typedef struct packed {
		logic [10:0] ev;
		logic [7:0]  flags;
	} tir_row_t;

	logic          mclk;
	logic          resetn;
	tir_reg_req_t  reg_req;
	logic [7:0]    reg_rdata;
	tir_events_t   events;
	logic [7:0]    aux_flags;
	logic [1:0]    proto_mode;
	logic          rats_valid;
	logic [3:0]    rats_fsdi;
	logic [3:0]    rats_cid;
	logic          set_default;
	logic          nvm_pu;
	logic          nvm_act;
	logic          irq;
	logic [7:0]    rd;
	int            errors;
	int            tests_run;
	int            cycles;
	// Event pulses beside the main flag value they should leave behind
	tir_row_t      rows [10] = '{{11'h200, 8'h20}, {11'h400, 8'h40}, {11'h140, 8'h10},
		{11'h100, 8'h00}, {11'h0C0, 8'h08}, {11'h030, 8'h04}, {11'h020, 8'h00},
		{11'h00A, 8'h02}, {11'h005, 8'h02}, {11'h009, 8'h00}};

	tir_irq_ctrl tir_irq_ctrl_i (
		.mclk                   (mclk),
		.resetn                 (resetn),
		.reg_req                (reg_req),
		.reg_rdata              (reg_rdata),
		.events                 (events),
		.aux_flags              (aux_flags),
		.proto_mode             (proto_mode),
		.rats_valid             (rats_valid),
		.rats_fsdi              (rats_fsdi),
		.rats_cid               (rats_cid),
		.set_default            (set_default),
		.nvm_enable_powerup_irq (nvm_pu),
		.nvm_enable_active_irq  (nvm_act),
		.irq                    (irq)
	);

	tir_host_model tir_host_model_i (
		.mclk      (mclk),
		.reg_req   (reg_req),
		.reg_rdata (reg_rdata)
	);

	// 25 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic stop_test();
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard: the run needs well under a thousand cycles
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			errors++;
			stop_test();
		end
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			errors++;
		end
	endtask

	task automatic chk_reg(input string name, input logic [7:0] addr, input logic [7:0] exp);
		tir_host_model_i.read_reg(addr, rd);
		check(name, rd, exp);
	endtask

	task automatic do_reset();
		resetn <= 1'b0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
	endtask

	// Pulse for one cycle, then wait until irq has had its cycle of lag
	task automatic pulse_ev(input logic [10:0] e);
		@(posedge mclk);
		events <= e;
		@(posedge mclk);
		events <= '0;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic rats(input logic [1:0] mode, input logic [3:0] f, input logic [3:0] c);
		@(posedge mclk);
		proto_mode <= mode;
		rats_valid <= 1'b1;
		rats_fsdi  <= f;
		rats_cid   <= c;
		@(posedge mclk);
		rats_valid <= 1'b0;
	endtask

	// Main sequence
	initial
	begin
		resetn = 1'b0;
		events = '0;
		aux_flags = 8'h00;
		proto_mode = 2'h1;
		rats_valid = 1'b0;
		rats_fsdi = 4'h0;
		rats_cid = 4'h0;
		set_default = 1'b0;
		nvm_pu = 1'b0;
		nvm_act = 1'b0;
		errors = 0;
		tests_run = 0;
		cycles = 0;
		do_reset();
		check("irq_masked_pu", {7'h00, irq}, 8'h00);
		chk_reg("main_mask_rst", 8'h08, 8'hC0);
		chk_reg("aux_mask_rst", 8'h09, 8'h00);
		chk_reg("params_rst", 8'h05, 8'h00);
		chk_reg("flags_pu", 8'h0A, 8'h80);
		chk_reg("flags_cleared", 8'h0A, 8'h00);
		tir_host_model_i.write_reg(8'h08, 8'hFF);
		chk_reg("main_mask_rsvd", 8'h08, 8'hFE);
		tir_host_model_i.write_reg(8'h09, 8'hA5);
		chk_reg("aux_mask_wr", 8'h09, 8'hA5);
		tir_host_model_i.write_reg(8'h05, 8'hFF);
		chk_reg("params_ro", 8'h05, 8'h00);
		chk_reg("unmapped", 8'h3C, 8'h00);
		tir_host_model_i.write_reg(8'h08, 8'h00);
		tir_host_model_i.write_reg(8'h09, 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			pulse_ev(rows[i].ev);
			check("irq_event", {7'h00, irq}, {7'h00, |rows[i].flags});
			chk_reg("flags_event", 8'h0A, rows[i].flags);
		end
		// Masked source sets its flag but leaves irq low
		tir_host_model_i.write_reg(8'h08, 8'h20);
		pulse_ev(11'h200);
		check("irq_masked", {7'h00, irq}, 8'h00);
		chk_reg("flags_masked", 8'h0A, 8'h20);
		// Aux summary survives a main read and clears only after the aux read
		@(posedge mclk);
		aux_flags <= 8'h04;
		repeat (3) @(posedge mclk);
		#1;
		check("irq_aux", {7'h00, irq}, 8'h01);
		chk_reg("flags_aux", 8'h0A, 8'h01);
		chk_reg("flags_aux_kept", 8'h0A, 8'h01);
		tir_host_model_i.write_reg(8'h09, 8'h04);
		repeat (2) @(posedge mclk);
		#1;
		check("irq_aux_masked", {7'h00, irq}, 8'h00);
		@(posedge mclk);
		aux_flags <= 8'h00;
		chk_reg("aux_read", 8'h0B, 8'h00);
		chk_reg("flags_aux_gone", 8'h0A, 8'h00);
		// Reader parameters, mode gating, restore defaults
		rats(2'h0, 4'hA, 4'h5);
		chk_reg("params_l4", 8'h05, 8'hA5);
		rats(2'h1, 4'h3, 4'hC);
		chk_reg("params_other", 8'h05, 8'hA5);
		tir_host_model_i.write_reg(8'h08, 8'h3E);
		@(posedge mclk);
		set_default <= 1'b1;
		@(posedge mclk);
		set_default <= 1'b0;
		chk_reg("params_dflt", 8'h05, 8'h00);
		chk_reg("main_mask_dflt", 8'h08, 8'hC0);
		chk_reg("aux_mask_dflt", 8'h09, 8'h00);
		// Second reset with both enable bits set unmasks the power-up source
		@(posedge mclk);
		nvm_pu <= 1'b1;
		nvm_act <= 1'b1;
		do_reset();
		repeat (2) @(posedge mclk);
		#1;
		check("nvm_enable_powerup_irq", {7'h00, irq}, 8'h01);
		chk_reg("main_mask_nvm", 8'h08, 8'h00);
		chk_reg("flags_pu2", 8'h0A, 8'h80);
		stop_test();
	end
endmodule

`default_nettype wire

// >>> verif/tir_host_model.sv
/*
 * Host controller model: register writes and reads toward the interrupt block.
 * Assumes requests are sampled on rising mclk and read data lands one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

module tir_host_model (
	input  wire logic                  mclk,
	output var  tir_pkg::tir_reg_req_t reg_req,
	input  wire logic [7:0]            reg_rdata
);
	import tir_pkg::*;

	// Bus starts idle
	initial
	begin
		reg_req = '0;
	end

	// One strobe cycle; idle address and data are inverted so leftovers never look valid
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge mclk);
		reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
	endtask

	// Data is taken after the edge that sampled the strobe
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge mclk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge mclk);
		reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
		#1 data = reg_rdata;
	endtask
endmodule

`default_nettype wire
